// ==== hw/gip_pkg.sv ====
// Constants and types shared by the two-wire target port
package gip_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	// Longest spike that the line filter must swallow
	localparam int GLITCH_NS = 50;
	// A new level must persist this many cycles beyond the first sample
	localparam logic [1:0] GLITCH_CYC =
		2'((GLITCH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [6:0] OWN_ADDR_BASE = 7'h20;
	localparam int LINE_SCL = 0;
	localparam int LINE_SDA = 1;
	localparam int PIN_PWR = 0;
	localparam int PIN_SEL = 1;
	localparam int PIN_CS_N = 2;
	localparam int PIN_SA = 3;
	localparam logic [1:0] K_ADDR = 2'h0;
	localparam logic [1:0] K_REG = 2'h1;
	localparam logic [1:0] K_DATA = 2'h2;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [3:0] BITS_LAST = 4'h7;
	localparam logic [7:0] PTR_STEP = 8'h01;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_MACK,
		ST_IGNORE
	} gip_state_e;
endpackage

// ==== hw/gip_line_if.sv ====
// Filtered bus line levels passed from the line filter to the port logic
`timescale 1ns/100ps
interface gip_line_if;
	logic scl;
	logic sda;
	modport src (output scl, output sda);
	modport dst (input scl, input sda);
endinterface

// ==== hw/gip_line_filter.sv ====
// Synchroniser and spike filter for the two bus lines
`timescale 1ns/100ps
module gip_line_filter (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic [1:0] line_raw,
	gip_line_if.src         bus
);
	typedef struct packed {
		logic [1:0]      s1;
		logic [1:0]      s2;
		logic [1:0]      out;
		logic [1:0][1:0] cnt;
	} gip_filt_s;

	localparam gip_filt_s FILT_RST = '{s1: 2'h3, s2: 2'h3, out: 2'h3,
		cnt: '0};

	gip_filt_s r;
	gip_filt_s n;

	always_comb begin
		n = r;
		n.s1 = line_raw;
		n.s2 = r.s1;
		for (int i = 0; i < 2; i++) begin
			// Level must differ from the output for several samples in a row
			if (r.s2[i] == r.out[i]) begin
				n.cnt[i] = '0;
			end else if (r.cnt[i] == gip_pkg::GLITCH_CYC) begin
				n.out[i] = r.s2[i];
				n.cnt[i] = '0;
			end else begin
				n.cnt[i] = r.cnt[i] + 2'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= FILT_RST;
		end else begin
			r <= n;
		end
	end

	assign bus.scl = r.out[gip_pkg::LINE_SCL];
	assign bus.sda = r.out[gip_pkg::LINE_SDA];

	generate
		for (genvar g = 0; g < 2; g++) begin : g_chk
			glitch_reject_a: assert property (@(posedge sys_clk)
				disable iff (sys_rst)
				$changed(r.out[g]) |-> $past(r.s2[g], 1) == r.out[g]
				&& $past(r.s2[g], 2) == r.out[g]
				&& $past(r.s2[g], 3) == r.out[g])
				else $error("line output changed on a short pulse");
		end
	endgenerate
endmodule // gip_line_filter

// ==== hw/gip_target.sv ====
// Two-wire bus target port in front of the sensor register file
`timescale 1ns/100ps
module gip_target (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       address_select_or_serial_out,
	input  wire logic       iface_select,
	input  wire logic       chip_select_n,
	input  wire logic       core_power_good,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	typedef struct packed {
		gip_pkg::gip_state_e st;
		logic [3:0]          bits;
		logic [7:0]          sh;
		logic [1:0]          kind;
		logic                rd;
		logic                mack;
		logic [7:0]          ptr;
		logic                sda_low;
		logic                scl_q;
		logic                sda_q;
		logic [3:0]          m1;
		logic [3:0]          m2;
		logic [7:0]          addr;
		logic [7:0]          wdata;
		logic                wr;
		logic                rdreq;
	} gip_port_s;

	// Edge history starts at the idle bus level, so no false edge follows reset
	localparam gip_port_s PORT_RST = '{st: gip_pkg::ST_IDLE, scl_q: 1'b1,
		sda_q: 1'b1, default: '0};

	gip_port_s  r;
	gip_port_s  n;
	gip_line_if line_bus ();
	logic       active;
	logic [6:0] own_addr;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_condition;
	logic       stop_condition;

	gip_line_filter u_filter (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.line_raw ({sda_in, scl_in}),
		.bus      (line_bus)
	);

	// Core powered, two-wire mode strapped, chip select held high
	assign active = r.m2[gip_pkg::PIN_PWR] & ~r.m2[gip_pkg::PIN_SEL]
		& r.m2[gip_pkg::PIN_CS_N];
	assign own_addr = {gip_pkg::OWN_ADDR_BASE[6:1],
		r.m2[gip_pkg::PIN_SA]};
	assign scl_rise = line_bus.scl & ~r.scl_q;
	assign scl_fall = ~line_bus.scl & r.scl_q;
	assign start_condition = line_bus.scl & r.scl_q & r.sda_q & ~line_bus.sda;
	assign stop_condition = line_bus.scl & r.scl_q & ~r.sda_q & line_bus.sda;

	always_comb begin
		n = r;
		n.wr = 1'b0;
		n.rdreq = 1'b0;
		n.m1 = {address_select_or_serial_out, chip_select_n, iface_select,
			core_power_good};
		n.m2 = r.m1;
		n.scl_q = line_bus.scl;
		n.sda_q = line_bus.sda;
		if (!active) begin
			n.st = gip_pkg::ST_IDLE;
			n.sda_low = 1'b0;
		end else if (start_condition) begin
			// Start and repeated start both restart address reception
			n.st = gip_pkg::ST_RX;
			n.bits = '0;
			n.kind = gip_pkg::K_ADDR;
			n.sda_low = 1'b0;
		end else if (stop_condition) begin
			n.st = gip_pkg::ST_IDLE;
			n.sda_low = 1'b0;
		end else begin
			case (r.st)
				gip_pkg::ST_RX: begin
					if (scl_rise) begin
						n.sh = {r.sh[6:0], line_bus.sda};
						n.bits = r.bits + 4'h1;
					end
					if (scl_fall && r.bits == gip_pkg::BITS_BYTE) begin
						n.st = gip_pkg::ST_ACK;
						n.sda_low = 1'b1;
						case (r.kind)
							gip_pkg::K_ADDR: begin
								if (r.sh[7:1] == own_addr) begin
									n.rd = r.sh[0];
									n.rdreq = r.sh[0];
									n.addr = r.ptr;
								end else begin
									n.st = gip_pkg::ST_IGNORE;
									n.sda_low = 1'b0;
								end
							end
							gip_pkg::K_REG: begin
								n.ptr = r.sh;
							end
							default: begin
								n.wr = 1'b1;
								n.addr = r.ptr;
								n.wdata = r.sh;
								n.ptr = r.ptr + gip_pkg::PTR_STEP;
							end
						endcase
					end
				end
				gip_pkg::ST_ACK: begin
					if (scl_fall && r.rd) begin
						n.st = gip_pkg::ST_TX;
						n.sh = reg_rdata;
						n.sda_low = ~reg_rdata[7];
						n.bits = '0;
						n.ptr = r.ptr + gip_pkg::PTR_STEP;
					end else if (scl_fall) begin
						n.st = gip_pkg::ST_RX;
						n.sda_low = 1'b0;
						n.bits = '0;
						n.kind = (r.kind == gip_pkg::K_ADDR) ?
							gip_pkg::K_REG : gip_pkg::K_DATA;
					end
				end
				gip_pkg::ST_TX: begin
					// Data changes only after the controller lowers the clock
					if (scl_fall && r.bits == gip_pkg::BITS_LAST) begin
						n.st = gip_pkg::ST_MACK;
						n.sda_low = 1'b0;
					end else if (scl_fall) begin
						n.sh = {r.sh[6:0], 1'b0};
						n.sda_low = ~r.sh[6];
						n.bits = r.bits + 4'h1;
					end
				end
				gip_pkg::ST_MACK: begin
					if (scl_rise) begin
						n.mack = ~line_bus.sda;
						n.rdreq = ~line_bus.sda;
						n.addr = r.ptr;
					end
					if (scl_fall && r.mack) begin
						n.st = gip_pkg::ST_TX;
						n.sh = reg_rdata;
						n.sda_low = ~reg_rdata[7];
						n.bits = '0;
						n.ptr = r.ptr + gip_pkg::PTR_STEP;
					end else if (scl_fall) begin
						n.st = gip_pkg::ST_IGNORE;
					end
				end
				default: begin
					n.sda_low = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= PORT_RST;
		end else begin
			r <= n;
		end
	end

	// Open drain data; the clock line is never pulled low
	assign sda_out = 1'b0;
	assign sda_oe = r.sda_low;
	assign scl_out = 1'b0;
	assign scl_oe = 1'b0;
	assign reg_addr = r.addr;
	assign reg_wdata = r.wdata;
	assign reg_wr = r.wr;
	assign reg_rd = r.rdreq;

	no_stretch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!scl_oe && (!sda_oe
		|| r.st inside {gip_pkg::ST_ACK, gip_pkg::ST_TX}))
		else $error("clock line driven or data driven out of slot");
	shutdown_quiet_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		!r.m2[gip_pkg::PIN_PWR] |=> !sda_oe && !reg_wr && !reg_rd)
		else $error("bus activity while core unpowered");
	mode_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r.m2[gip_pkg::PIN_SEL] || !r.m2[gip_pkg::PIN_CS_N] |=> !sda_oe)
		else $error("two-wire port active outside its mode");
	addr_ack_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r.st == gip_pkg::ST_RX && r.kind == gip_pkg::K_ADDR && active
		&& !start_condition && !stop_condition && scl_fall
		&& r.bits == gip_pkg::BITS_BYTE
		&& r.sh[7:1] == {6'h10, r.m2[gip_pkg::PIN_SA]} |=> sda_oe)
		else $error("own address not acknowledged");
	addr_nak_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r.st == gip_pkg::ST_RX && r.kind == gip_pkg::K_ADDR && scl_fall
		&& r.bits == gip_pkg::BITS_BYTE
		&& r.sh[7:1] != {6'h10, r.m2[gip_pkg::PIN_SA]}
		|=> !sda_oe && !reg_wr && !reg_rd)
		else $error("foreign address acknowledged");
	read_dir_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r.st == gip_pkg::ST_ACK && r.rd && scl_fall && active
		&& !start_condition && !stop_condition |=> r.st == gip_pkg::ST_TX)
		else $error("read direction did not start sending");
	wr_ptr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr |-> r.ptr == reg_addr + 8'h01 && r.st == gip_pkg::ST_ACK
		&& sda_oe)
		else $error("write pointer did not advance");
	rd_ptr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		r.st != gip_pkg::ST_TX ##1 r.st == gip_pkg::ST_TX
		|-> r.ptr == $past(r.ptr) + 8'h01)
		else $error("read pointer did not advance");
endmodule // gip_target

// ==== bench/gip_ctrl_model.sv ====
// Behavioural two-wire bus controller for the target port
`timescale 1ns/100ps
module gip_ctrl_model (
	input  wire logic sys_clk,
	input  wire logic sda_bus,
	output logic      scl_pin,
	output logic      sda_low
);
	// A bit is 64 cycles (2.56 us, about 390 kHz); lines idle released
	logic glitch;
	initial begin
		scl_pin = 1'b1;
		sda_low = 1'b0;
		glitch = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic bit_out(input logic b);
		sda_low <= ~b;
		if (glitch) begin
			wt(8);
			scl_pin <= 1'b1; // 40 ns clock spike
			wt(1);
			scl_pin <= 1'b0;
			wt(7);
		end else begin
			wt(16);
		end
		scl_pin <= 1'b1;
		wt(32);
		scl_pin <= 1'b0;
		wt(16);
	endtask
	task automatic bit_in(output logic b);
		sda_low <= 1'b0;
		wt(16);
		scl_pin <= 1'b1;
		wt(16);
		b = sda_bus;
		wt(16);
		scl_pin <= 1'b0;
		wt(16);
	endtask
	// Also serves as repeated start
	task automatic start();
		sda_low <= 1'b0;
		wt(16);
		scl_pin <= 1'b1;
		wt(32);
		sda_low <= 1'b1;
		wt(32);
		scl_pin <= 1'b0;
		wt(16);
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		wt(16);
		scl_pin <= 1'b1;
		wt(32);
		sda_low <= 1'b0;
		wt(32);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(b);
		ack = ~b;
	endtask
	task automatic rbyte(output logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(~ack);
	endtask
endmodule // gip_ctrl_model

// ==== bench/gip_target_tb.sv ====
// Self-checking bench for the two-wire target port
`timescale 1ns/100ps
module gip_target_tb;
	logic sys_clk, sys_rst, scl_pin, sda_low, scl_out, scl_oe, sda_out;
	logic sda_oe, sa, sel, cs_n, pwr, reg_wr, reg_rd, stretched, a;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, n, o;
	logic [7:0] mem [256];
	logic [7:0] wr_cnt, oe_cnt;
	int         fail_count, checks;
	// Open-drain lines with pull-ups; a driven line shows the port's value
	wire        sda_bus = ~sda_low & (sda_oe ? sda_out : 1'b1);
	wire        scl_bus = scl_pin & (scl_oe ? scl_out : 1'b1);
	gip_target u_gip_target (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.scl_in(scl_bus), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe),
		.address_select_or_serial_out(sa), .iface_select(sel),
		.chip_select_n(cs_n), .core_power_good(pwr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	gip_ctrl_model u_gip_ctrl_model (.sys_clk(sys_clk), .sda_bus(sda_bus),
		.scl_pin(scl_pin), .sda_low(sda_low));
	always #20 sys_clk = ~sys_clk;
	// Register file stand-in plus activity counters
	always @(posedge sys_clk) begin
		if (reg_wr) mem[reg_addr] <= reg_wdata;
		if (reg_rd) reg_rdata <= mem[reg_addr];
		wr_cnt <= wr_cnt + 8'(reg_wr);
		oe_cnt <= oe_cnt + 8'(sda_oe);
		if (scl_oe !== 1'b0) stretched <= 1'b1;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] ad, pt, dt, output logic ack);
		logic x;
		u_gip_ctrl_model.start();
		u_gip_ctrl_model.wbyte(ad, ack);
		u_gip_ctrl_model.wbyte(pt, x);
		u_gip_ctrl_model.wbyte(dt, x);
		u_gip_ctrl_model.stop();
	endtask
	task automatic t_write();
		sa <= 1'b1;
		u_gip_ctrl_model.start();
		u_gip_ctrl_model.wbyte(8'h42, a);
		chk(8'(a), 8'h01);
		u_gip_ctrl_model.wbyte(8'h10, a);
		u_gip_ctrl_model.glitch = 1'b1;
		u_gip_ctrl_model.wbyte(8'hAA, a);
		u_gip_ctrl_model.glitch = 1'b0;
		chk(8'(a), 8'h01);
		u_gip_ctrl_model.wbyte(8'h55, a);
		u_gip_ctrl_model.stop();
		chk(mem[8'h10], 8'hAA);
		chk(mem[8'h11], 8'h55);
		$display("test write done");
	endtask
	task automatic t_read();
		u_gip_ctrl_model.start();
		u_gip_ctrl_model.wbyte(8'h42, a);
		u_gip_ctrl_model.wbyte(8'h10, a);
		u_gip_ctrl_model.start();
		u_gip_ctrl_model.wbyte(8'h43, a);
		chk(8'(a), 8'h01);
		u_gip_ctrl_model.rbyte(d, 1'b1);
		chk(d, 8'hAA);
		u_gip_ctrl_model.rbyte(d, 1'b0);
		chk(d, 8'h55);
		u_gip_ctrl_model.stop();
		$display("test read done");
	endtask
	task automatic t_addr();
		sa <= 1'b0;
		xfer(8'h42, 8'h20, 8'h33, a);
		chk(8'(a), 8'h00);
		xfer(8'h40, 8'h20, 8'h5A, a);
		chk(8'(a), 8'h01);
		chk(mem[8'h20], 8'h5A);
		$display("test address done");
	endtask
	task automatic t_off();
		n = wr_cnt;
		o = oe_cnt;
		pwr <= 1'b0;
		xfer(8'h40, 8'h30, 8'h66, a);
		chk(8'(a), 8'h00);
		pwr <= 1'b1;
		sel <= 1'b1;
		xfer(8'h40, 8'h30, 8'h66, a);
		chk(8'(a), 8'h00);
		sel <= 1'b0;
		cs_n <= 1'b0;
		xfer(8'h40, 8'h30, 8'h66, a);
		chk(8'(a), 8'h00);
		cs_n <= 1'b1;
		chk(wr_cnt - n, 8'h00);
		chk(oe_cnt - o, 8'h00);
		xfer(8'h40, 8'h31, 8'h77, a);
		chk(8'(a), 8'h01);
		chk(mem[8'h31], 8'h77);
		chk(8'(stretched), 8'h00);
		$display("test off done");
	endtask
	task automatic end_sim();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#3_000_000;
		fail_count++;
		end_sim();
	end
	initial begin
		{sys_clk, sa, sel, stretched, wr_cnt, oe_cnt, reg_rdata} = '0;
		{sys_rst, cs_n, pwr} = 3'h7;
		fail_count = 0;
		checks = 0;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge sys_clk);
		t_write();
		t_read();
		t_addr();
		t_off();
		end_sim();
	end
endmodule // gip_target_tb
